// >>> design/amp_power_gain_control_regs.sv
// Contract
// R1: the page selector chooses which page the next paged access addresses.
// R2: writing one to the reset bit starts a self-clearing software reset; zero does nothing.
// R3: power bits 7..3 of control a enable processor, pll, n divider, modulator dac and adc.
// R4: brownout or clock halt sets the fault flag and powers several blocks down.
// R5: software clears the fault flag before powering the device back up.
// R6: the cause of a fault is recorded in the interrupt status register.
// R7: control b bit 7 enables the output stage and bit 5 the boost converter.
// R8: control b bit 1 enables current sense and bit 0 voltage sense.
// R9: gain bits 6..3 give the dac gain in dB equal to the code, 0 to 15.
// R10: edge bits 2..0 select output transition time 50,40,29,25,14,13,12,11 ns.
// R11: the page selector holds until rewritten or reset to page zero.
`timescale 1ns/1ps
`include "amp_regs_defs.svh"

module amp_power_gain_control_regs
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic brownout_pin,
    input wire logic clock_halt_pin,
    output logic processor_power_on,
    output logic synth_loop_power_on,
    output logic n_divider_power_on,
    output logic modulator_dac_power_on,
    output logic modulator_adc_power_on,
    output logic output_stage_power_on,
    output logic boost_converter_power_on,
    output logic current_sense_power_on,
    output logic voltage_sense_power_on,
    output logic [3:0] dac_gain_db,
    output logic [2:0] edge_rate_code,
    output logic [7:0] active_page,
    output logic [7:0] paged_access_addr,
    output logic paged_access_write,
    output logic paged_access_strobe,
    output logic [7:0] paged_access_wdata,
    output logic soft_reset_active,
    output logic irq
);
    import amp_regs_pkg::*;

    // ========================================
    // input synchronisers
    logic [1:0] bo_sync_reg, bo_sync_next;
    logic [1:0] ch_sync_reg, ch_sync_next;

    always_comb
    begin
        bo_sync_next = {bo_sync_reg[0], brownout_pin};
        ch_sync_next = {ch_sync_reg[0], clock_halt_pin};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bo_sync_reg <= 2'h0;
            ch_sync_reg <= 2'h0;
        end
        else
        begin
            bo_sync_reg <= bo_sync_next;
            ch_sync_reg <= ch_sync_next;
        end
    end

    logic brownout_s, clock_halt_s, fault_event;
    assign brownout_s = bo_sync_reg[1];
    assign clock_halt_s = ch_sync_reg[1];
    assign fault_event = brownout_s | clock_halt_s;

    // ========================================
    // bus address phase capture
    bus_state_type st_reg, st_next;
    logic wr_reg, wr_next;
    logic [7:0] idx_reg, idx_next;
    logic take;
    assign take = hsel & hready & htrans[1];

    always_comb
    begin
        st_next = st_reg;
        wr_next = wr_reg;
        idx_next = idx_reg;
        case (st_reg)
            BUS_IDLE, BUS_DATA:
            begin
                if (take)
                begin
                    st_next = BUS_DATA;
                    wr_next = hwrite;
                    idx_next = haddr[9:2];
                end
                else if (hready)
                begin
                    st_next = BUS_IDLE;
                    wr_next = 1'b0;
                end
            end
            default: st_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= BUS_IDLE;
            wr_reg <= 1'b0;
            idx_reg <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
            wr_reg <= wr_next;
            idx_reg <= idx_next;
        end
    end

    logic dwrite;
    assign dwrite = (st_reg == BUS_DATA) & wr_reg;

    // ========================================
    // register file
    reg8_type page_reg, page_next;
    reg8_type pwr_a_reg, pwr_a_next;
    reg8_type pwr_b_reg, pwr_b_next;
    reg8_type gain_reg, gain_next;
    cause_type stat_reg, stat_next;
    cause_type mask_reg, mask_next;
    logic [3:0] srst_cnt_reg, srst_cnt_next;
    logic soft_rst;
    assign soft_rst = (srst_cnt_reg != 4'h0);

    always_comb
    begin
        page_next = page_reg;
        pwr_a_next = pwr_a_reg;
        pwr_b_next = pwr_b_reg;
        gain_next = gain_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        srst_cnt_next = soft_rst ? srst_cnt_reg - 4'h1 : 4'h0;
        if (dwrite)
        begin
            case (idx_reg)
                `IDX_PAGE_SELECT: page_next = hwdata[7:0]; // R1 R11
                `IDX_SOFTWARE_RESET_CTL:
                begin
                    if (hwdata[`BIT_SW_RESET])
                        srst_cnt_next = `SW_RESET_CYCLES; // R2
                end
                `IDX_BLOCK_POWER_CTL_A: pwr_a_next = hwdata[7:0]; // R3 R5
                `IDX_BLOCK_POWER_CTL_B: pwr_b_next = hwdata[7:0]; // R7 R8
                `IDX_GAIN_AND_SLEW_CTL: gain_next = hwdata[7:0]; // R9 R10
                `IDX_FAULT_STATUS: stat_next = stat_reg & ~hwdata[1:0];
                `IDX_FAULT_MASK: mask_next = hwdata[1:0];
                default: ;
            endcase
        end
        // fault wins over a same-cycle clear; blocks dropped, flag kept
        if (fault_event)
        begin
            pwr_a_next = {5'h00, pwr_a_next[2:1], 1'b1}; // R4
            pwr_b_next = 8'h00; // R4
        end
        if (brownout_s)
            stat_next[`BIT_CAUSE_BROWNOUT] = 1'b1; // R6
        if (clock_halt_s)
            stat_next[`BIT_CAUSE_CLOCK_HALT] = 1'b1; // R6
        if (soft_rst)
        begin
            page_next = `RST_PAGE; // R11
            pwr_a_next = `RST_REG8;
            pwr_b_next = `RST_REG8;
            gain_next = `RST_REG8;
            stat_next = `RST_CAUSE;
            mask_next = `RST_CAUSE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            page_reg <= `RST_PAGE;
            pwr_a_reg <= `RST_REG8;
            pwr_b_reg <= `RST_REG8;
            gain_reg <= `RST_REG8;
            stat_reg <= `RST_CAUSE;
            mask_reg <= `RST_CAUSE;
            srst_cnt_reg <= 4'h0;
        end
        else
        begin
            page_reg <= page_next;
            pwr_a_reg <= pwr_a_next;
            pwr_b_reg <= pwr_b_next;
            gain_reg <= gain_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            srst_cnt_reg <= srst_cnt_next;
        end
    end

    // ========================================
    // read data, paged window and outputs
    logic [31:0] rdata_next;
    logic [7:0] paddr_next, pwdata_next;
    logic pstrobe_next, pwrite_next, irq_next;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        // next values, so a read right behind a write already sees it
        if (take & ~hwrite)
        begin
            case (haddr[9:2])
                `IDX_PAGE_SELECT: rdata_next = {24'h000000, page_next};
                `IDX_SOFTWARE_RESET_CTL: rdata_next = 32'h0000_0000; // R2
                `IDX_BLOCK_POWER_CTL_A: rdata_next = {24'h000000, pwr_a_next};
                `IDX_BLOCK_POWER_CTL_B: rdata_next = {24'h000000, pwr_b_next};
                `IDX_GAIN_AND_SLEW_CTL: rdata_next = {24'h000000, gain_next};
                `IDX_FAULT_STATUS: rdata_next = {30'h0, stat_next};
                `IDX_FAULT_MASK: rdata_next = {30'h0, mask_next};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // paged window: writes at 0x80+ go out tagged with the page
        pstrobe_next = dwrite & (idx_reg >= `IDX_PAGED_WINDOW); // R1
        pwrite_next = dwrite;
        paddr_next = idx_reg - `IDX_PAGED_WINDOW;
        pwdata_next = hwdata[7:0];
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            paged_access_strobe <= 1'b0;
            paged_access_write <= 1'b0;
            paged_access_addr <= 8'h00;
            paged_access_wdata <= 8'h00;
            irq <= 1'b0;
            processor_power_on <= 1'b0;
            synth_loop_power_on <= 1'b0;
            n_divider_power_on <= 1'b0;
            modulator_dac_power_on <= 1'b0;
            modulator_adc_power_on <= 1'b0;
            output_stage_power_on <= 1'b0;
            boost_converter_power_on <= 1'b0;
            current_sense_power_on <= 1'b0;
            voltage_sense_power_on <= 1'b0;
            dac_gain_db <= 4'h0;
            edge_rate_code <= 3'h0;
            active_page <= 8'h00;
            soft_reset_active <= 1'b0;
        end
        else
        begin
            hrdata <= rdata_next;
            // zero wait, always okay; still from flops like every other output
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            paged_access_strobe <= pstrobe_next;
            paged_access_write <= pwrite_next;
            paged_access_addr <= paddr_next;
            paged_access_wdata <= pwdata_next;
            irq <= irq_next;
            {processor_power_on, synth_loop_power_on, n_divider_power_on,
             modulator_dac_power_on, modulator_adc_power_on} <= pwr_a_next[7:3]; // R3 R4
            output_stage_power_on <= pwr_b_next[`BIT_OUTPUT_STAGE_POWER_ON]; // R7
            boost_converter_power_on <= pwr_b_next[`BIT_BOOST_CONVERTER_POWER_ON]; // R7
            current_sense_power_on <= pwr_b_next[`BIT_CURRENT_SENSE_POWER_ON]; // R8
            voltage_sense_power_on <= pwr_b_next[`BIT_VOLTAGE_SENSE_POWER_ON]; // R8
            dac_gain_db <= gain_next[`GAIN_MSB:`GAIN_LSB]; // R9
            edge_rate_code <= gain_next[`EDGE_MSB:`EDGE_LSB]; // R10
            active_page <= page_next; // R1
            soft_reset_active <= (srst_cnt_next != 4'h0);
        end
    end

    // ========================================
    // assertions
    a_fault_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        fault_event && !soft_rst |=> pwr_a_reg[0])
        else $error("fault did not set flag");
    a_fault_powers_down: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        fault_event |=> !processor_power_on && !output_stage_power_on)
        else $error("fault left blocks powered");
    a_cause_recorded: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        brownout_s && !soft_rst |=> stat_reg[0])
        else $error("brownout cause lost");
    a_halt_recorded: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        clock_halt_s && !soft_rst |=> stat_reg[1])
        else $error("clock halt cause lost");
    a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        (stat_reg & mask_reg) != 2'h0 |-> irq)
        else $error("unmasked cause without interrupt");
    a_reset_self_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        $rose(soft_rst) |-> ##[1:4] !soft_rst)
        else $error("software reset stuck");
    a_reset_zero_noop: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        dwrite && idx_reg == 8'h01 && !hwdata[0] && !soft_rst |=> !soft_rst)
        else $error("zero write started a reset");
    a_reset_clears_page: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        soft_rst |=> page_reg == 8'h00)
        else $error("page not cleared by reset");
    a_page_holds: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        !dwrite && !soft_rst |=> $stable(page_reg))
        else $error("page changed without write");
    a_page_write: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        dwrite && idx_reg == 8'h00 && !soft_rst |=> page_reg == $past(hwdata[7:0]))
        else $error("page write lost");
    a_gain_output: assert property (@(posedge hclk) disable iff (!hresetn) // R9 R10
        dac_gain_db == gain_reg[6:3] && edge_rate_code == gain_reg[2:0])
        else $error("gain or edge output wrong");
    a_power_b_output: assert property (@(posedge hclk) disable iff (!hresetn) // R7 R8
        boost_converter_power_on == pwr_b_reg[5] && current_sense_power_on == pwr_b_reg[1])
        else $error("power b output wrong");
    a_power_a_output: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        synth_loop_power_on == pwr_a_reg[6] && modulator_adc_power_on == pwr_a_reg[3])
        else $error("power a output wrong");

    c_fault: cover property (@(posedge hclk) disable iff (!hresetn) $rose(pwr_a_reg[0]));
    c_soft_reset: cover property (@(posedge hclk) disable iff (!hresetn) $rose(soft_rst));
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_paged: cover property (@(posedge hclk) disable iff (!hresetn) paged_access_strobe);

endmodule // amp_power_gain_control_regs

// >>> design/amp_regs_defs.svh
`ifndef AMP_REGS_DEFS_SVH
`define AMP_REGS_DEFS_SVH

// register indices (byte address = 4 * index)
`define IDX_PAGE_SELECT 8'h00
`define IDX_SOFTWARE_RESET_CTL 8'h01
`define IDX_BLOCK_POWER_CTL_A 8'h04
`define IDX_BLOCK_POWER_CTL_B 8'h05
`define IDX_GAIN_AND_SLEW_CTL 8'h06
`define IDX_FAULT_STATUS 8'h10
`define IDX_FAULT_MASK 8'h11
`define IDX_PAGED_WINDOW 8'h20

// field positions
`define BIT_SW_RESET 0
`define BIT_PROCESSOR_POWER_ON 7
`define BIT_MODULATOR_ADC_POWER_ON 3
`define BIT_POWER_FAULT_FLAG 0
`define BIT_OUTPUT_STAGE_POWER_ON 7
`define BIT_BOOST_CONVERTER_POWER_ON 5
`define BIT_CURRENT_SENSE_POWER_ON 1
`define BIT_VOLTAGE_SENSE_POWER_ON 0
`define GAIN_MSB 6
`define GAIN_LSB 3
`define EDGE_MSB 2
`define EDGE_LSB 0
`define BIT_CAUSE_BROWNOUT 0
`define BIT_CAUSE_CLOCK_HALT 1

// reset values
`define RST_PAGE 8'h00
`define RST_REG8 8'h00
`define RST_CAUSE 2'h0

// software reset pulse length in cycles
`define SW_RESET_CYCLES 4'h4

`endif

// >>> design/amp_regs_pkg.sv
package amp_regs_pkg;
    typedef logic [7:0] reg8_type;
    typedef logic [1:0] cause_type;
    typedef enum logic [1:0] {SEL_NONE, SEL_A, SEL_B, SEL_C} unused_sel_type;
    typedef enum {BUS_IDLE, BUS_DATA} bus_state_type;
endpackage

// >>> tb/tb.sv
`timescale 1ns/1ps
`include "amp_regs_defs.svh"

module tb;
    // ==========================================================
    // signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic brownout_pin = 1'b0;
    logic clock_halt_pin = 1'b0;
    logic [31:0] hrdata, v;
    logic hreadyout, hresp, irq, soft_reset_active;
    logic processor_power_on, synth_loop_power_on, n_divider_power_on;
    logic modulator_dac_power_on, modulator_adc_power_on, output_stage_power_on;
    logic boost_converter_power_on, current_sense_power_on, voltage_sense_power_on;
    logic [3:0] dac_gain_db;
    logic [2:0] edge_rate_code;
    logic [7:0] active_page, paged_access_addr, paged_access_wdata, strobe_page;
    logic [7:0] strobe_addr, strobe_data;
    logic paged_access_write, paged_access_strobe, strobe_write;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int strobes = 0;
    wire logic hready = hreadyout;
    wire logic [15:0] obs = {processor_power_on, synth_loop_power_on, n_divider_power_on,
        modulator_dac_power_on, modulator_adc_power_on, output_stage_power_on,
        boost_converter_power_on, current_sense_power_on, voltage_sense_power_on,
        dac_gain_db, edge_rate_code};

    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [7:0] rd; logic [15:0] ob;} row_type;
    row_type rows [8] = '{
        '{`IDX_PAGE_SELECT, 32'h0000005a, 8'h5a, 16'h0000},
        '{`IDX_BLOCK_POWER_CTL_A, 32'hffffffa8, 8'ha8, 16'ha800},
        '{`IDX_BLOCK_POWER_CTL_B, 32'h000000a1, 8'ha1, 16'hae80},
        '{`IDX_BLOCK_POWER_CTL_B, 32'h00000022, 8'h22, 16'hab00},
        '{`IDX_GAIN_AND_SLEW_CTL, 32'h00000055, 8'h55, 16'hab55},
        '{8'h02, 32'h000000ff, 8'h00, 16'hab55},
        '{`IDX_SOFTWARE_RESET_CTL, 32'h00000000, 8'h00, 16'hab55},
        '{`IDX_BLOCK_POWER_CTL_A, 32'h00000050, 8'h50, 16'h5355}};

    amp_power_gain_control_regs amp_power_gain_control_regs_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .brownout_pin(brownout_pin), .clock_halt_pin(clock_halt_pin),
        .processor_power_on(processor_power_on), .synth_loop_power_on(synth_loop_power_on),
        .n_divider_power_on(n_divider_power_on),
        .modulator_dac_power_on(modulator_dac_power_on),
        .modulator_adc_power_on(modulator_adc_power_on),
        .output_stage_power_on(output_stage_power_on),
        .boost_converter_power_on(boost_converter_power_on),
        .current_sense_power_on(current_sense_power_on),
        .voltage_sense_power_on(voltage_sense_power_on),
        .dac_gain_db(dac_gain_db), .edge_rate_code(edge_rate_code),
        .active_page(active_page), .paged_access_addr(paged_access_addr),
        .paged_access_write(paged_access_write), .paged_access_strobe(paged_access_strobe),
        .paged_access_wdata(paged_access_wdata), .soft_reset_active(soft_reset_active),
        .irq(irq));

    // ==========================================================
    // clock, capture and timeout
    initial
    begin
        forever #12.5 hclk = ~hclk;
    end

    // paged strobe capture and cycle ceiling
    always @(posedge hclk)
    begin
        if (paged_access_strobe === 1'b1)
        begin
            strobes++;
            strobe_write <= paged_access_write;
            strobe_addr <= paged_access_addr;
            strobe_data <= paged_access_wdata;
            strobe_page <= active_page;
        end
        cycles++;
        if (cycles >= 3000)
        begin
            fail_count++;
            final_report();
        end
    end

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // read data still stands at the edge that ends the data phase
        v = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(idx, 1'b0, 32'h0);
        check(v, {24'h0, exp});
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        check({obs, active_page, 4'h0, ~hreadyout, hresp, irq, soft_reset_active}, 32'h0);
        rd_chk(`IDX_PAGE_SELECT, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            xfer(rows[i].idx, 1'b1, rows[i].wd);
            rd_chk(rows[i].idx, rows[i].rd);
            check({16'h0, obs}, {16'h0, rows[i].ob});
        end
        for (int g = 0; g < 16; g++)
        begin
            xfer(`IDX_GAIN_AND_SLEW_CTL, 1'b1, {25'h0, g[3:0], g[2:0]});
            @(posedge hclk);
            check({25'h0, dac_gain_db, edge_rate_code}, {25'h0, g[3:0], g[2:0]});
        end
        // paged window: page stays in force across the other accesses
        xfer(8'h23, 1'b1, 32'h0000003c);
        repeat (2) @(posedge hclk);
        check({strobes[15:0], strobe_addr, strobe_data}, {16'h1, 8'h03, 8'h3c});
        check({23'h0, strobe_write, strobe_page}, {23'h0, 1'b1, 8'h5a});
        // brownout while blocks are powered
        xfer(`IDX_BLOCK_POWER_CTL_B, 1'b1, 32'h000000a3);
        brownout_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        brownout_pin <= 1'b0;
        repeat (6) @(posedge hclk);
        rd_chk(`IDX_BLOCK_POWER_CTL_A, 8'h01);
        rd_chk(`IDX_BLOCK_POWER_CTL_B, 8'h00);
        rd_chk(`IDX_FAULT_STATUS, 8'h01);
        check({15'h0, obs, irq}, {15'h0, 16'h007f, 1'b0});
        xfer(`IDX_FAULT_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        xfer(`IDX_FAULT_STATUS, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        rd_chk(`IDX_FAULT_STATUS, 8'h00);
        check({31'h0, irq}, 32'h0);
        // clock halt: a masked cause keeps the interrupt quiet
        clock_halt_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        clock_halt_pin <= 1'b0;
        repeat (6) @(posedge hclk);
        rd_chk(`IDX_FAULT_STATUS, 8'h02);
        check({31'h0, irq}, 32'h0);
        xfer(`IDX_FAULT_MASK, 1'b1, 32'h3);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        xfer(`IDX_FAULT_STATUS, 1'b1, 32'h2);
        // flag cleared before powering up again
        xfer(`IDX_BLOCK_POWER_CTL_A, 1'b1, 32'h0);
        xfer(`IDX_BLOCK_POWER_CTL_A, 1'b1, 32'hf8);
        rd_chk(`IDX_BLOCK_POWER_CTL_A, 8'hf8);
        check({31'h0, irq}, 32'h0);
        // software reset
        xfer(`IDX_SOFTWARE_RESET_CTL, 1'b1, 32'h1);
        @(posedge hclk);
        check({31'h0, soft_reset_active}, 32'h1);
        repeat (8) @(posedge hclk);
        check({31'h0, soft_reset_active}, 32'h0);
        rd_chk(`IDX_SOFTWARE_RESET_CTL, 8'h00);
        rd_chk(`IDX_PAGE_SELECT, 8'h00);
        rd_chk(`IDX_BLOCK_POWER_CTL_A, 8'h00);
        rd_chk(`IDX_FAULT_MASK, 8'h00);
        check({obs, active_page, 8'h0}, 32'h0);
        final_report();
    end
endmodule // tb
